// *** dcg_pkg.sv ***
// constants for the dll and clock doubler setup block
package dcg_pkg;
   localparam logic [7:0] ADDR_RX_DBL_CTRL = 8'h39;
   localparam logic [7:0] ADDR_RX_DBL_OFFSET = 8'h3B;
   localparam logic [7:0] ADDR_RX_DBL_TAP = 8'h3C;
   localparam logic [7:0] ADDR_DLL_ENABLE = 8'h60;
   localparam logic [7:0] ADDR_RX_CLK_DRIVE = 8'h63;
   localparam logic [7:0] ADDR_DUTY_BYPASS = 8'h66;
   localparam logic [7:0] ADDR_DLL_SRC_DIV = 8'h71;
   localparam logic [7:0] ADDR_DLL_MULT_LOCK = 8'h72;
   localparam logic [7:0] ADDR_DLL_RESET = 8'h75;
   localparam logic [7:0] ADDR_BUS_RATE = 8'h30;

   localparam logic [7:0] RST_RX_DBL_CTRL = 8'h00;
   localparam logic [7:0] RST_RX_DBL_OFFSET = 8'h5D;
   localparam logic [7:0] RST_RX_DBL_TAP = 8'h00;
   localparam logic [7:0] RST_DLL_ENABLE = 8'h00;
   localparam logic [7:0] RST_RX_CLK_DRIVE = 8'h00;
   localparam logic [7:0] RST_DUTY_BYPASS = 8'h00;
   localparam logic [7:0] RST_DLL_SRC_DIV = 8'h00;
   localparam logic [5:0] RST_DLL_MULT = 6'h00;
   localparam logic [7:0] RST_DLL_RESET = 8'h00;
   localparam logic [1:0] RST_BUS_RATE = 2'h0;

   localparam int BIT_DLL_ENABLE = 7;
   localparam int BIT_TX_SRC_DLL = 6;
   localparam int BIT_TX_DBL_SEL = 5;
   localparam int BIT_DLL_REF_EN = 4;
   localparam int DIV_MSB = 3;
   localparam int MULT_MSB = 5;
   localparam int BIT_DLL_LOCK = 7;
   localparam int BIT_DLL_RESET = 3;
   localparam int BIT_RX_DBL_RESET = 7;
   localparam int BIT_RX_CLK_DBL = 1;
   localparam int DRIVE_LSB = 2;
   localparam int DRIVE_MSB = 3;
   localparam int BIT_DUTY_BYPASS = 2;
   localparam int OFFSET_LSB = 3;
   localparam int OFFSET_MSB = 4;
   localparam int BIT_RX_DDR = 0;
   localparam int BIT_TX_DDR = 1;

   localparam int RATE_W = 11;
   localparam logic [10:0] RATE_PRESCALE = 11'h040;

   localparam int CLK_PERIOD_NS = 10;
   localparam int DLL_LOCK_NS = 1000;
   localparam int DLL_LOCK_CYCLES = (DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] DLL_LOCK_COUNT = 8'(DLL_LOCK_CYCLES);
endpackage

// *** dcg_rate_if.sv ***
// rate request and tick between the top and a rate generator
`timescale 1ns/100ps
`default_nettype none
interface dcg_rate_if;
   logic [10:0] num;
   logic [10:0] den;
   logic en;
   logic tick;
   modport gen (input num, input den, input en, output tick);
   modport user (output num, output den, output en, input tick);
endinterface
`default_nettype wire

// *** dcg_rate_gen.sv ***
// fractional rate generator giving num/den enable ticks per clock
`timescale 1ns/100ps
`default_nettype none
module dcg_rate_gen
   import dcg_pkg::*;
(
   input wire logic REF_CLK_I, // 100 MHz clock
   input wire logic RSTN_I, // synchronous reset, active low
   dcg_rate_if.gen rate // rate request and tick
);
   logic [RATE_W:0] acc_reg;
   logic [RATE_W:0] acc_next;
   logic tick_reg;
   logic tick_next;
   logic [RATE_W:0] sum;

   // at most one tick per cycle; ratios above one saturate
   always_comb begin
      sum = acc_reg + {1'b0, rate.num};
      acc_next = acc_reg;
      tick_next = 1'b0;
      if (!rate.en || rate.den == '0) begin
         acc_next = '0;
      end else if (sum >= {1'b0, rate.den}) begin
         acc_next = sum - {1'b0, rate.den};
         if (acc_next >= {1'b0, rate.den}) begin
            acc_next = '0;
         end
         tick_next = 1'b1;
      end else begin
         acc_next = sum;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         acc_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         tick_reg <= tick_next;
      end
   end

   assign rate.tick = tick_reg;
endmodule
`default_nettype wire

// *** dcg_clock_setup.sv ***
// dll and clock doubler configuration registers with lock tracking
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - dll multiplies then divides for transmit clock
// - multiplier field M gives M plus one
// - 0x80 to 0x60 enables the dll
// - 0x53 to 0x71 selects dll, reference, divide three
// - both data buses start single data rate
// - lock shown in bit 7 of 0x72
// - receive doubler doubles main clock when enabled
// - transmit doubler doubles clock, selectable for output
// - 0x02 to 0x39 selects doubler for receive output
// - bit 7 of 0x39 holds doubler in reset
// - 0x08 to 0x63 sets drive level two
module dcg_clock_setup
   import dcg_pkg::*;
(
   input wire logic REF_CLK_I, // main clock, 100 MHz
   input wire logic RSTN_I, // synchronous reset, active low
   input wire logic REG_WR_I, // register write strobe
   input wire logic REG_RD_I, // register read strobe
   input wire logic [7:0] REG_ADDR_I, // register address
   input wire logic [7:0] REG_WDATA_I, // register write data
   output logic [7:0] REG_RDATA_O, // register read data
   output logic REG_RVALID_O, // read data valid pulse
   output logic DLL_ENABLE_O, // dll block enabled
   output logic DLL_REF_EN_O, // dll reference enabled
   output logic DLL_RESET_O, // dll held in reset
   output logic DLL_LOCKED_O, // dll lock status
   output logic [6:0] DLL_MULT_O, // effective multiplication
   output logic [3:0] DLL_DIV_O, // divisor
   output logic TX_SRC_DLL_O, // transmit converter clock from dll
   output logic TX_DBL_SEL_O, // transmit doubler in transmit clock output
   output logic RX_DBL_EN_O, // receive doubler in sample clock path
   output logic RX_DBL_RESET_O, // receive doubler held in reset
   output logic [1:0] RX_DBL_OFFSET_O, // doubler offset
   output logic [7:0] RX_DBL_TAP_O, // doubler tap delay
   output logic [1:0] RX_CLK_DRIVE_O, // receive clock output drive level
   output logic DUTY_BYPASS_O, // duty cycle stabilizer bypassed
   output logic RX_BUS_DDR_O, // receive bus double data rate
   output logic TX_BUS_DDR_O, // transmit bus double data rate
   output logic TX_CONV_TICK_O, // transmit converter clock enable
   output logic TX_CLK_OUT_TICK_O, // transmit clock output enable
   output logic RX_SAMPLE_TICK_O // receive sample clock enable
);
   logic [7:0] rx_dbl_ctrl_reg, rx_dbl_ctrl_next;
   logic [7:0] rx_dbl_offset_reg, rx_dbl_offset_next;
   logic [7:0] rx_dbl_tap_reg, rx_dbl_tap_next;
   logic [7:0] dll_enable_reg, dll_enable_next;
   logic [7:0] rx_clk_drive_reg, rx_clk_drive_next;
   logic [7:0] duty_bypass_reg, duty_bypass_next;
   logic [7:0] dll_src_div_reg, dll_src_div_next;
   logic [5:0] dll_mult_reg, dll_mult_next;
   logic [7:0] dll_reset_reg, dll_reset_next;
   logic [1:0] bus_rate_reg, bus_rate_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;

   logic [7:0] lock_cnt_reg, lock_cnt_next;
   logic locked_reg, locked_next;
   logic [6:0] mult_out_reg, mult_out_next;
   logic [3:0] div_eff;
   logic dll_run;
   logic dll_cfg_wr;

   dcg_rate_if conv_if ();
   dcg_rate_if txo_if ();
   dcg_rate_if rxs_if ();

   // register writes; unmapped addresses are ignored
   always_comb begin
      rx_dbl_ctrl_next = rx_dbl_ctrl_reg;
      rx_dbl_offset_next = rx_dbl_offset_reg;
      rx_dbl_tap_next = rx_dbl_tap_reg;
      dll_enable_next = dll_enable_reg;
      rx_clk_drive_next = rx_clk_drive_reg;
      duty_bypass_next = duty_bypass_reg;
      dll_src_div_next = dll_src_div_reg;
      dll_mult_next = dll_mult_reg;
      dll_reset_next = dll_reset_reg;
      bus_rate_next = bus_rate_reg;
      if (REG_WR_I) begin
         if (REG_ADDR_I == ADDR_RX_DBL_CTRL) begin
            rx_dbl_ctrl_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_RX_DBL_OFFSET) begin
            rx_dbl_offset_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_RX_DBL_TAP) begin
            rx_dbl_tap_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_DLL_ENABLE) begin
            dll_enable_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_RX_CLK_DRIVE) begin
            rx_clk_drive_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_DUTY_BYPASS) begin
            duty_bypass_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_DLL_SRC_DIV) begin
            dll_src_div_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_DLL_MULT_LOCK) begin
            dll_mult_next = REG_WDATA_I[MULT_MSB:0];
         end else if (REG_ADDR_I == ADDR_DLL_RESET) begin
            dll_reset_next = REG_WDATA_I;
         end else if (REG_ADDR_I == ADDR_BUS_RATE) begin
            bus_rate_next = REG_WDATA_I[1:0];
         end
      end
   end

   // reads answer one cycle later; unmapped reads return zero
   always_comb begin
      rvalid_next = REG_RD_I;
      rdata_next = rdata_reg;
      if (REG_RD_I) begin
         if (REG_ADDR_I == ADDR_RX_DBL_CTRL) begin
            rdata_next = rx_dbl_ctrl_reg;
         end else if (REG_ADDR_I == ADDR_RX_DBL_OFFSET) begin
            rdata_next = rx_dbl_offset_reg;
         end else if (REG_ADDR_I == ADDR_RX_DBL_TAP) begin
            rdata_next = rx_dbl_tap_reg;
         end else if (REG_ADDR_I == ADDR_DLL_ENABLE) begin
            rdata_next = dll_enable_reg;
         end else if (REG_ADDR_I == ADDR_RX_CLK_DRIVE) begin
            rdata_next = rx_clk_drive_reg;
         end else if (REG_ADDR_I == ADDR_DUTY_BYPASS) begin
            rdata_next = duty_bypass_reg;
         end else if (REG_ADDR_I == ADDR_DLL_SRC_DIV) begin
            rdata_next = dll_src_div_reg;
         end else if (REG_ADDR_I == ADDR_DLL_MULT_LOCK) begin
            rdata_next = {locked_reg, 1'b0, dll_mult_reg};
         end else if (REG_ADDR_I == ADDR_DLL_RESET) begin
            rdata_next = dll_reset_reg;
         end else if (REG_ADDR_I == ADDR_BUS_RATE) begin
            rdata_next = {6'h00, bus_rate_reg};
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         rx_dbl_ctrl_reg <= RST_RX_DBL_CTRL;
         rx_dbl_offset_reg <= RST_RX_DBL_OFFSET;
         rx_dbl_tap_reg <= RST_RX_DBL_TAP;
         dll_enable_reg <= RST_DLL_ENABLE;
         rx_clk_drive_reg <= RST_RX_CLK_DRIVE;
         duty_bypass_reg <= RST_DUTY_BYPASS;
         dll_src_div_reg <= RST_DLL_SRC_DIV;
         dll_mult_reg <= RST_DLL_MULT;
         dll_reset_reg <= RST_DLL_RESET;
         bus_rate_reg <= RST_BUS_RATE;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rx_dbl_ctrl_reg <= rx_dbl_ctrl_next;
         rx_dbl_offset_reg <= rx_dbl_offset_next;
         rx_dbl_tap_reg <= rx_dbl_tap_next;
         dll_enable_reg <= dll_enable_next;
         rx_clk_drive_reg <= rx_clk_drive_next;
         duty_bypass_reg <= duty_bypass_next;
         dll_src_div_reg <= dll_src_div_next;
         dll_mult_reg <= dll_mult_next;
         dll_reset_reg <= dll_reset_next;
         bus_rate_reg <= bus_rate_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // lock tracking: a change of ratio means the loop must settle again
   assign dll_run = dll_enable_reg[BIT_DLL_ENABLE] && dll_src_div_reg[BIT_DLL_REF_EN] &&
                    !dll_reset_reg[BIT_DLL_RESET];
   assign dll_cfg_wr = REG_WR_I && (REG_ADDR_I == ADDR_DLL_SRC_DIV || REG_ADDR_I == ADDR_DLL_MULT_LOCK);
   assign div_eff = (dll_src_div_reg[DIV_MSB:0] == 4'h0) ? 4'h1 : dll_src_div_reg[DIV_MSB:0];

   always_comb begin
      lock_cnt_next = lock_cnt_reg;
      locked_next = locked_reg;
      mult_out_next = {1'b0, dll_mult_reg} + 7'h01;
      if (!dll_run || dll_cfg_wr) begin
         lock_cnt_next = 8'h00;
         locked_next = 1'b0;
      end else if (lock_cnt_reg < DLL_LOCK_COUNT) begin
         lock_cnt_next = lock_cnt_reg + 8'h01;
      end else begin
         locked_next = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         lock_cnt_reg <= 8'h00;
         locked_reg <= 1'b0;
         mult_out_reg <= 7'h01;
      end else begin
         lock_cnt_reg <= lock_cnt_next;
         locked_reg <= locked_next;
         mult_out_reg <= mult_out_next;
      end
   end

   // rates are scaled down by the prescale so the ticks fit one per cycle
   always_comb begin
      if (dll_src_div_reg[BIT_TX_SRC_DLL]) begin
         conv_if.num = {4'h0, mult_out_reg};
         conv_if.den = 11'(div_eff * RATE_PRESCALE);
         conv_if.en = locked_reg;
      end else begin
         conv_if.num = 11'h001;
         conv_if.den = RATE_PRESCALE;
         conv_if.en = 1'b1;
      end
      txo_if.num = dll_src_div_reg[BIT_TX_DBL_SEL] ? {conv_if.num[9:0], 1'b0} : conv_if.num;
      txo_if.den = conv_if.den;
      txo_if.en = conv_if.en;
      rxs_if.num = rx_dbl_ctrl_reg[BIT_RX_CLK_DBL] ? 11'h002 : 11'h001;
      rxs_if.den = RATE_PRESCALE;
      rxs_if.en = !rx_dbl_ctrl_reg[BIT_RX_DBL_RESET];
   end

   dcg_rate_gen u_conv (
      .REF_CLK_I(REF_CLK_I),
      .RSTN_I(RSTN_I),
      .rate(conv_if.gen)
   );

   dcg_rate_gen u_txo (
      .REF_CLK_I(REF_CLK_I),
      .RSTN_I(RSTN_I),
      .rate(txo_if.gen)
   );

   dcg_rate_gen u_rxs (
      .REF_CLK_I(REF_CLK_I),
      .RSTN_I(RSTN_I),
      .rate(rxs_if.gen)
   );

   assign REG_RDATA_O = rdata_reg;
   assign REG_RVALID_O = rvalid_reg;
   assign DLL_ENABLE_O = dll_enable_reg[BIT_DLL_ENABLE];
   assign DLL_REF_EN_O = dll_src_div_reg[BIT_DLL_REF_EN];
   assign DLL_RESET_O = dll_reset_reg[BIT_DLL_RESET];
   assign DLL_LOCKED_O = locked_reg;
   assign DLL_MULT_O = mult_out_reg;
   assign DLL_DIV_O = dll_src_div_reg[DIV_MSB:0];
   assign TX_SRC_DLL_O = dll_src_div_reg[BIT_TX_SRC_DLL];
   assign TX_DBL_SEL_O = dll_src_div_reg[BIT_TX_DBL_SEL];
   assign RX_DBL_EN_O = rx_dbl_ctrl_reg[BIT_RX_CLK_DBL];
   assign RX_DBL_RESET_O = rx_dbl_ctrl_reg[BIT_RX_DBL_RESET];
   assign RX_DBL_OFFSET_O = rx_dbl_offset_reg[OFFSET_MSB:OFFSET_LSB];
   assign RX_DBL_TAP_O = rx_dbl_tap_reg;
   assign RX_CLK_DRIVE_O = rx_clk_drive_reg[DRIVE_MSB:DRIVE_LSB];
   assign DUTY_BYPASS_O = duty_bypass_reg[BIT_DUTY_BYPASS];
   assign RX_BUS_DDR_O = bus_rate_reg[BIT_RX_DDR];
   assign TX_BUS_DDR_O = bus_rate_reg[BIT_TX_DDR];
   assign TX_CONV_TICK_O = conv_if.tick;
   assign TX_CLK_OUT_TICK_O = txo_if.tick;
   assign RX_SAMPLE_TICK_O = rxs_if.tick;
endmodule
`default_nettype wire

// *** dcg_clock_setup_properties.sv ***
// checker for the clock setup block ports
`timescale 1ns/100ps
`default_nettype none
module dcg_clock_setup_properties
   import dcg_pkg::*;
(
   input wire logic REF_CLK_I, // clock
   input wire logic RSTN_I, // reset, active low
   input wire logic REG_WR_I, // write strobe
   input wire logic REG_RD_I, // read strobe
   input wire logic [7:0] REG_ADDR_I, // address
   input wire logic [7:0] REG_WDATA_I, // write data
   input wire logic [7:0] REG_RDATA_O, // read data
   input wire logic REG_RVALID_O, // read valid
   input wire logic DLL_ENABLE_O, // dll enabled
   input wire logic DLL_REF_EN_O, // dll reference
   input wire logic DLL_RESET_O, // dll reset
   input wire logic DLL_LOCKED_O, // lock
   input wire logic [6:0] DLL_MULT_O, // multiplication
   input wire logic TX_SRC_DLL_O, // tx source
   input wire logic RX_DBL_EN_O, // rx doubler
   input wire logic RX_DBL_RESET_O, // rx doubler reset
   input wire logic RX_BUS_DDR_O, // rx bus rate
   input wire logic RX_SAMPLE_TICK_O // rx sample tick
);
   logic [7:0] lk_cnt_reg;
   logic [7:0] lk_cnt_next;
   logic lk_run;
   logic wr_cfg;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   assign lk_run = DLL_ENABLE_O && DLL_REF_EN_O && !DLL_RESET_O;
   assign wr_cfg = REG_WR_I && (REG_ADDR_I == ADDR_DLL_SRC_DIV || REG_ADDR_I == ADDR_DLL_MULT_LOCK);
   // cycles since the lock condition started, restarted by config writes
   always_comb begin
      lk_cnt_next = lk_cnt_reg;
      if (!lk_run || wr_cfg) begin
         lk_cnt_next = 8'h00;
      end else if (lk_cnt_reg != 8'hFF) begin
         lk_cnt_next = lk_cnt_reg + 8'h01;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         lk_cnt_reg <= 8'h00;
      end else begin
         lk_cnt_reg <= lk_cnt_next;
      end
   end
   property p_enable;
      REG_WR_I && REG_ADDR_I == ADDR_DLL_ENABLE |=> DLL_ENABLE_O == $past(REG_WDATA_I[7]);
   endproperty
   a_enable: assert property (p_enable) else $error("dll enable wrong");
   property p_dll_rst;
      REG_WR_I && REG_ADDR_I == ADDR_DLL_RESET |=> DLL_RESET_O == $past(REG_WDATA_I[BIT_DLL_RESET]);
   endproperty
   a_dll_rst: assert property (p_dll_rst) else $error("dll reset bit wrong");
   property p_src;
      REG_WR_I && REG_ADDR_I == ADDR_DLL_SRC_DIV |=> TX_SRC_DLL_O == $past(REG_WDATA_I[6]) &&
         DLL_REF_EN_O == $past(REG_WDATA_I[4]);
   endproperty
   a_src: assert property (p_src) else $error("dll source wrong");
   property p_mult;
      REG_WR_I && REG_ADDR_I == ADDR_DLL_MULT_LOCK |=> ##1 DLL_MULT_O == {1'b0, $past(REG_WDATA_I[5:0], 2)} + 7'h01;
   endproperty
   a_mult: assert property (p_mult) else $error("multiplication wrong");
   property p_lock_off;
      !lk_run |=> !DLL_LOCKED_O;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock while stopped");
   property p_lock_early;
      $rose(DLL_LOCKED_O) |-> lk_cnt_reg >= 8'h62 && lk_cnt_reg <= 8'h68;
   endproperty
   a_lock_early: assert property (p_lock_early) else $error("lock at wrong time");
   property p_lock_late;
      lk_cnt_reg == 8'h6A |-> DLL_LOCKED_O;
   endproperty
   a_lock_late: assert property (p_lock_late) else $error("lock missing");
   property p_rd_lock;
      REG_RD_I && REG_ADDR_I == ADDR_DLL_MULT_LOCK |=> REG_RDATA_O[7] == $past(DLL_LOCKED_O) && !REG_RDATA_O[6];
   endproperty
   a_rd_lock: assert property (p_rd_lock) else $error("lock bit read wrong");
   property p_rvalid;
      REG_RD_I |=> REG_RVALID_O;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid missing");
   property p_rx_dbl;
      REG_WR_I && REG_ADDR_I == ADDR_RX_DBL_CTRL |=> RX_DBL_EN_O == $past(REG_WDATA_I[1]) &&
         RX_DBL_RESET_O == $past(REG_WDATA_I[7]);
   endproperty
   a_rx_dbl: assert property (p_rx_dbl) else $error("rx doubler control wrong");
   property p_rx_hold;
      RX_DBL_RESET_O [*3] |-> !RX_SAMPLE_TICK_O;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("sample tick in doubler reset");
   property p_sdr;
      $changed(RX_BUS_DDR_O) |-> $past(REG_WR_I && REG_ADDR_I == ADDR_BUS_RATE);
   endproperty
   a_sdr: assert property (p_sdr) else $error("bus rate changed unasked");
endmodule
bind dcg_clock_setup dcg_clock_setup_properties i_props (.REF_CLK_I, .RSTN_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
   .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .DLL_ENABLE_O, .DLL_REF_EN_O, .DLL_RESET_O, .DLL_LOCKED_O,
   .DLL_MULT_O, .TX_SRC_DLL_O, .RX_DBL_EN_O, .RX_DBL_RESET_O, .RX_BUS_DDR_O, .RX_SAMPLE_TICK_O);
`default_nettype wire

// *** dcg_host_model.sv ***
// host controller model for the register port
`timescale 1ns/100ps
`default_nettype none
module dcg_host_model
   import dcg_pkg::*;
(
   input wire logic clk_i, // clock
   output logic wr_o, // write strobe
   output logic rd_o, // read strobe
   output logic [7:0] addr_o, // address
   output logic [7:0] wdata_o, // write data
   input wire logic [7:0] rdata_i, // read data
   input wire logic rvalid_i // read valid
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // idle lines carry the inverse so stale values cannot pass
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      d = rdata_i;
      v = rvalid_i;
   endtask
   task automatic dll_config();
      wr_reg(ADDR_DLL_ENABLE, 8'h80);
      wr_reg(ADDR_DLL_SRC_DIV, 8'h53);
      wr_reg(ADDR_DLL_MULT_LOCK, 8'h09);
   endtask
   task automatic dll_pulse(input int gap);
      repeat (gap) @(posedge clk_i);
      wr_reg(ADDR_DLL_RESET, 8'h08);
      repeat (gap) @(posedge clk_i);
      wr_reg(ADDR_DLL_RESET, 8'h00);
   endtask
   // receive doubler in use, duty stabilizer bypassed when slow is set
   task automatic dbl_config(input logic slow);
      wr_reg(ADDR_RX_DBL_TAP, 8'h00);
      wr_reg(ADDR_RX_DBL_CTRL, 8'h02);
      if (slow) begin
         wr_reg(ADDR_DUTY_BYPASS, 8'h04);
      end
      wr_reg(ADDR_RX_DBL_OFFSET, 8'h55);
   endtask
   task automatic dbl_pulse(input int gap);
      repeat (gap) @(posedge clk_i);
      wr_reg(ADDR_RX_DBL_CTRL, 8'h82);
      repeat (gap) @(posedge clk_i);
      wr_reg(ADDR_RX_DBL_CTRL, 8'h02);
      wr_reg(ADDR_RX_CLK_DRIVE, 8'h08);
   endtask
endmodule
`default_nettype wire

// *** dll_and_clock_doubler_setup_bench.sv ***
// testbench for the dll and clock doubler setup block
`timescale 1ns/100ps
`default_nettype none
module dll_and_clock_doubler_setup_bench;
   import dcg_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wr, rd, rvalid, en, ref_en, dll_rst, lock, src, tx_sel, rx_en, rx_rst, bypass, rx_ddr, tx_ddr;
   logic t_conv, t_out, t_rx, clr;
   logic [7:0] addr, wdata, rdata, tap;
   logic [6:0] mult;
   logic [3:0] div;
   logic [1:0] offs, drive;
   int cr, ct, co, bad_count, n_compared;
   always #5 clk = ~clk;
   dcg_host_model i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
      .rdata_i(rdata), .rvalid_i(rvalid));
   dcg_clock_setup i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .DLL_ENABLE_O(en),
      .DLL_REF_EN_O(ref_en), .DLL_RESET_O(dll_rst), .DLL_LOCKED_O(lock), .DLL_MULT_O(mult), .DLL_DIV_O(div),
      .TX_SRC_DLL_O(src), .TX_DBL_SEL_O(tx_sel), .RX_DBL_EN_O(rx_en), .RX_DBL_RESET_O(rx_rst),
      .RX_DBL_OFFSET_O(offs), .RX_DBL_TAP_O(tap), .RX_CLK_DRIVE_O(drive), .DUTY_BYPASS_O(bypass),
      .RX_BUS_DDR_O(rx_ddr), .TX_BUS_DDR_O(tx_ddr), .TX_CONV_TICK_O(t_conv), .TX_CLK_OUT_TICK_O(t_out),
      .RX_SAMPLE_TICK_O(t_rx));
   initial clr = 1'b0;
   always @(posedge clk) begin
      if (clr) begin
         cr <= 0;
         ct <= 0;
         co <= 0;
      end else begin
         cr <= cr + int'(t_rx);
         ct <= ct + int'(t_conv);
         co <= co + int'(t_out);
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic in_range(input int v, input int lo, input int hi);
      check({7'h00, v >= lo && v <= hi}, 8'h01);
   endtask
   // rate generators start at any phase, so counts get a small margin
   task automatic count(input int n);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_lock(output int n);
      n = 0;
      while (lock !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic t_reset_vals();
      logic [7:0] a [11] = '{8'h39, 8'h3B, 8'h3C, 8'h60, 8'h63, 8'h66, 8'h71, 8'h72, 8'h75, 8'h30, 8'h44};
      logic [7:0] e [11] = '{RST_RX_DBL_CTRL, RST_RX_DBL_OFFSET, RST_RX_DBL_TAP, RST_DLL_ENABLE,
         RST_RX_CLK_DRIVE, RST_DUTY_BYPASS, RST_DLL_SRC_DIV, 8'h00, RST_DLL_RESET, 8'h00, 8'h00};
      logic [7:0] d;
      logic v;
      i_host.wr_reg(8'h44, 8'hFF);
      for (int i = 0; i < 11; i++) begin
         i_host.rd_reg(a[i], d, v);
         check(d, e[i]);
         check({7'h00, v}, 8'h01);
      end
      check({6'h00, rx_ddr, tx_ddr}, 8'h00);
      check({1'b0, mult}, 8'h01);
   endtask
   task automatic t_dll();
      logic [7:0] d;
      logic v;
      int n;
      i_host.dll_config();
      // multiplication output trails the field by one more cycle
      repeat (2) @(posedge clk);
      check({1'b0, mult}, 8'h0A);
      check({en, ref_en, src, 1'b0, div}, 8'hE3);
      i_host.dll_pulse(50);
      check({7'h00, lock}, 8'h00);
      wait_lock(n);
      in_range(n, 98, 104);
      i_host.rd_reg(ADDR_DLL_MULT_LOCK, d, v);
      check(d, 8'h89);
      count(1920);
      in_range(ct, 98, 102);
      in_range(co, 98, 102);
      i_host.wr_reg(ADDR_DLL_ENABLE, 8'h00);
      @(posedge clk);
      @(posedge clk);
      check({7'h00, lock}, 8'h00);
      i_host.wr_reg(ADDR_DLL_ENABLE, 8'h80);
      wait_lock(n);
      in_range(n, 98, 104);
   endtask
   task automatic t_tx_dbl();
      int n;
      i_host.wr_reg(ADDR_DLL_SRC_DIV, 8'h73);
      // the ratio write restarts lock; let the drop show first
      repeat (2) @(posedge clk);
      check({7'h00, lock}, 8'h00);
      wait_lock(n);
      in_range(n, 98, 102);
      check({7'h00, tx_sel}, 8'h01);
      count(1920);
      in_range(ct, 98, 102);
      in_range(co, 196, 204);
   endtask
   task automatic t_rx_dbl();
      count(1280);
      in_range(cr, 19, 21);
      i_host.dbl_config(1'b1);
      @(posedge clk);
      check({rx_en, bypass, offs, 4'h0}, 8'hE0);
      check(tap, 8'h00);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      i_host.dbl_pulse(300);
      @(posedge clk);
      // about 303 running cycles at 2/64 before the hold, none during it
      in_range(cr, 8, 11);
      check({6'h00, rx_rst, 1'b0}, 8'h00);
      check({6'h00, drive}, 8'h02);
      count(1280);
      in_range(cr, 38, 42);
   endtask
   task automatic t_bus_rate();
      i_host.wr_reg(ADDR_BUS_RATE, 8'h03);
      @(posedge clk);
      check({6'h00, rx_ddr, tx_ddr}, 8'h03);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check({5'h00, rx_ddr, tx_ddr, lock}, 8'h00);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset_vals();
      t_dll();
      t_tx_dbl();
      t_rx_dbl();
      t_bus_rate();
      conclude();
   end
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
